// >>> design/pbsp_pkg.sv
// Constants and types shared by the burst SRAM access port.
// Assumes one clock domain; pins other than sleep, strap and output enable are synchronous.

package pbsp_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int ADDR_W_DEF   = 20;    // Word address bits
  localparam int LANES_DEF    = 4;     // Byte lanes per word
  localparam int BYTE_W       = 8;     // Data bits per lane
  localparam int LANE_W       = 9;     // Data plus parity per lane
  localparam int BEAT_W       = 2;     // Counter bits of the address
  localparam int BURST_LEN    = 4;     // Beats per burst group

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;  // System clock period
  localparam int SLEEP_CYCLES  = 2;    // Sleep entry and exit, in cycles

  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic       ORDER_LINEAR = 1'b0;  // Strap low
  localparam logic [1:0] BEAT_RST     = 2'h0;  // Counter after reset

  // Decoded command at a qualified edge
  typedef enum logic [3:0] {
    CMD_IDLE  = 4'h1,  // Deselect
    CMD_READ  = 4'h2,  // Start a read burst
    CMD_WRITE = 4'h4,  // Start a write burst
    CMD_STEP  = 4'h8   // Advance the burst
  } pbsp_cmd_t;

endpackage : pbsp_pkg

// >>> design/pbsp_mem_if.sv
// Memory-side connection between the port control and the array.
// Assumes the array writes on the system clock and reads combinationally.
`timescale 1ns/100ps

interface pbsp_mem_if #(
  parameter int AW = pbsp_pkg::ADDR_W_DEF,
  parameter int NB = pbsp_pkg::LANES_DEF
);
  logic                          wr_en;    // Commit a write this edge
  logic [AW-1:0]                 wr_addr;  // Word to write
  logic [NB-1:0]                 wr_lane;  // Lanes to write, high active
  logic [NB*pbsp_pkg::LANE_W-1:0] wr_data; // Lanes with parity
  logic [AW-1:0]                 rd_addr;  // Word to read
  logic [NB*pbsp_pkg::LANE_W-1:0] rd_data; // Current array contents

  // Control side drives requests
  modport ctl (output wr_en, wr_addr, wr_lane, wr_data, rd_addr,
               input  rd_data);
  // Array side answers
  modport mem (input  wr_en, wr_addr, wr_lane, wr_data, rd_addr,
               output rd_data);
endinterface : pbsp_mem_if

// >>> design/pbsp_mem.sv
// Storage array with per-lane write and combinational read.
// Assumes the control side resolves same-edge read/write collisions.
`timescale 1ns/100ps

module pbsp_mem #(
  parameter int AW = pbsp_pkg::ADDR_W_DEF,
  parameter int NB = pbsp_pkg::LANES_DEF
) (
  input wire logic sys_clk,
  pbsp_mem_if.mem  port
);
  import pbsp_pkg::*;

  // ****************************************
  // Array
  // ****************************************
  // Not reset: contents survive reset and sleep alike
  logic [NB*LANE_W-1:0] mem_q [2**AW];

  // Lane-masked write; unselected lanes keep old data
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < NB; i++) begin
      if (port.wr_en && port.wr_lane[i]) begin
        mem_q[port.wr_addr][i*LANE_W +: LANE_W] <=
          port.wr_data[i*LANE_W +: LANE_W];
      end
    end
  end

  // Read is plain lookup; output register sits in the control
  assign port.rd_data = mem_q[port.rd_addr];

endmodule : pbsp_mem

// >>> design/pbsp_burst_ctr.sv
// Two-bit burst sequencer for the low address bits.
// Assumes load and step are already qualified and never both high.
`timescale 1ns/100ps

module pbsp_burst_ctr (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       load,        // Start a new burst
  input  wire logic       step,        // Advance one beat
  input  wire logic       order_sel,   // High interleaved, low linear
  input  wire logic [1:0] start_bits,  // Low address bits at load
  output logic      [1:0] cur_bits,    // Low bits of current beat
  output logic      [1:0] next_bits    // Low bits of following beat
);
  import pbsp_pkg::*;

  logic [1:0] start_q;  // Loaded low bits
  logic [1:0] cnt_q;    // Beat count, wraps by width

  // Beat address from start and count
  function automatic logic [1:0] beat_of(input logic [1:0] s,
                                         input logic [1:0] c,
                                         input logic       ord);
    if (ord == ORDER_LINEAR) begin
      beat_of = s + c;
    end else begin
      beat_of = s ^ c;
    end
  endfunction : beat_of

  // ****************************************
  // Counter state
  // ****************************************
  // Only two bits exist, so wrap inside the group is free
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      start_q <= BEAT_RST;
      cnt_q   <= BEAT_RST;
    end else if (load) begin
      start_q <= start_bits;
      cnt_q   <= BEAT_RST;
    end else if (step) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  assign cur_bits  = beat_of(start_q, cnt_q, order_sel);
  assign next_bits = beat_of(start_q, cnt_q + 2'h1, order_sel);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_load; load; endsequence
  sequence s_four; step [*4]; endsequence

  chk_load_start: assert property (
    s_load |=> cur_bits == $past(start_bits))
    else $error("burst start not loaded");
  chk_wrap_four: assert property (
    s_load ##1 s_four ##1 $stable(order_sel) |-> cur_bits == start_q)
    else $error("burst did not wrap after four beats");
  chk_linear_step: assert property (
    step && !order_sel ##1 !order_sel |-> cur_bits == $past(cur_bits) + 2'h1)
    else $error("linear beat not plus one");
  chk_inter_step: assert property (
    step && order_sel ##1 order_sel |->
      (cur_bits ^ start_q) == $past(cnt_q) + 2'h1)
    else $error("interleaved beat not start xor count");

endmodule : pbsp_burst_ctr

// >>> design/pbsp_top.sv
// Pipelined burst SRAM access port: command decode, burst, data pipe.
// Assumes controller pins are synchronous to sys_clk except sleep,
// the order strap and the output enable; pads are resolved outside.
`timescale 1ns/100ps

module pbsp_top #(
  parameter int AW = pbsp_pkg::ADDR_W_DEF,
  parameter int NB = pbsp_pkg::LANES_DEF
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clock_qualify_n,
  input  wire logic                  chip_select_one_n,
  input  wire logic                  chip_select_two,
  input  wire logic                  chip_select_three_n,
  input  wire logic                  burst_step_or_load,
  input  wire logic                  write_n,
  input  wire logic [NB-1:0]         byte_lane_write_n,
  input  wire logic [AW-1:0]         address,
  input  wire logic                  burst_order,
  input  wire logic                  output_enable_n,
  input  wire logic                  sleep_request,
  input  wire logic [NB*pbsp_pkg::BYTE_W-1:0] data_in,
  output logic      [NB*pbsp_pkg::BYTE_W-1:0] data_out,
  output logic                       data_oe,
  input  wire logic [NB-1:0]         parity_in,
  output logic      [NB-1:0]         parity_out,
  output logic                       parity_oe,
  output logic                       sleep_active
);
  import pbsp_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic              sleep_meta_q;   // Sleep synchroniser stage one
  logic              sleep_q;        // Sleep level in clock domain
  logic              order_meta_q;   // Strap synchroniser stage one
  logic              order_q;        // Strap level in clock domain
  logic              cs_all;         // All three selects active
  logic              go;             // Qualified, awake edge
  pbsp_cmd_t         cmd;            // Decoded command
  logic              burst_live_q;   // Burst may still be stepped
  logic              burst_write_q;  // Type of current burst
  logic [AW-1:0]     addr_hi_q;      // Address above counter bits
  logic [1:0]        beat_next;      // Counter low bits, next beat
  logic              ctr_load;       // Load counter
  logic              ctr_step;       // Step counter
  logic              a_valid_q;      // Address stage holds access
  logic              a_write_q;      // Address stage is a write
  logic [AW-1:0]     a_addr_q;       // Address stage word address
  logic [NB-1:0]     a_mask_n_q;     // Address stage lane selects
  logic              b_valid_q;      // Data stage holds a write
  logic [AW-1:0]     b_addr_q;       // Data stage word address
  logic [NB-1:0]     b_mask_n_q;     // Data stage lane selects
  logic              drive_q;        // Read data ready to drive
  logic [NB*LANE_W-1:0] dout_q;      // Output register, with parity
  logic [NB*LANE_W-1:0] wr_lanes;    // Incoming data as lanes
  logic [NB*LANE_W-1:0] rd_merged;   // Array data plus bypass
  logic              hit;            // Read meets same-edge write

  pbsp_mem_if #(.AW(AW), .NB(NB)) mif ();

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Sleep is asynchronous; two flops give the two-cycle entry and exit
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sleep_meta_q <= 1'b0;
      sleep_q      <= 1'b0;
    end else begin
      sleep_meta_q <= sleep_request;
      sleep_q      <= sleep_meta_q;
    end
  end

  // Strap may float during power-up, so it is synchronised too
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      order_meta_q <= ORDER_LINEAR;
      order_q      <= ORDER_LINEAR;
    end else begin
      order_meta_q <= burst_order;
      order_q      <= order_meta_q;
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  assign cs_all = !chip_select_one_n && chip_select_two &&
                  !chip_select_three_n;
  // Stall and sleep both block every command edge
  assign go = !clock_qualify_n && !sleep_q;

  // Step wins over selects and write strobe
  always_comb begin
    if (burst_step_or_load) begin
      cmd = CMD_STEP;
    end else if (cs_all) begin
      cmd = write_n ? CMD_READ : CMD_WRITE;
    end else begin
      cmd = CMD_IDLE;
    end
  end

  // ****************************************
  // Burst tracking
  // ****************************************
  // Type latched at load and reused on every step
  always_ff @(posedge sys_clk) begin
    if (!rst_n || sleep_q) begin
      burst_live_q  <= 1'b0;
      burst_write_q <= 1'b0;
      addr_hi_q     <= '0;
    end else if (go) begin
      case (cmd)
        CMD_READ, CMD_WRITE: begin
          burst_live_q  <= 1'b1;
          burst_write_q <= (cmd == CMD_WRITE);
          addr_hi_q     <= address;
        end
        CMD_IDLE: begin
          burst_live_q <= 1'b0;  // Stepping after this is idle
        end
        default: begin
          burst_live_q <= burst_live_q;  // Step keeps burst
        end
      endcase
    end
  end

  assign ctr_load = go && (cmd == CMD_READ || cmd == CMD_WRITE);
  assign ctr_step = go && (cmd == CMD_STEP) && burst_live_q;

  pbsp_burst_ctr u_ctr (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n && !sleep_q),
    .load       (ctr_load),
    .step       (ctr_step),
    .order_sel  (order_q),
    .start_bits (address[1:0]),
    .cur_bits   (),
    .next_bits  (beat_next)
  );

  // ****************************************
  // Address stage
  // ****************************************
  // One command per edge, so reads and writes run back to back
  always_ff @(posedge sys_clk) begin
    if (!rst_n || sleep_q) begin
      a_valid_q  <= 1'b0;  // Pending work dropped on sleep
      a_write_q  <= 1'b0;
      a_addr_q   <= '0;
      a_mask_n_q <= '1;
    end else if (go) begin
      a_mask_n_q <= byte_lane_write_n;
      case (cmd)
        CMD_READ, CMD_WRITE: begin
          a_valid_q <= 1'b1;
          a_write_q <= (cmd == CMD_WRITE);
          a_addr_q  <= address;
        end
        CMD_STEP: begin
          a_valid_q <= burst_live_q;
          a_write_q <= burst_write_q;
          a_addr_q  <= {addr_hi_q[AW-1:2], beat_next};
        end
        default: begin
          a_valid_q <= 1'b0;  // Deselect travels down the pipe
        end
      endcase
    end
  end

  // ****************************************
  // Write data stage
  // ****************************************
  // A write waits one edge here, so data arrives two edges late
  always_ff @(posedge sys_clk) begin
    if (!rst_n || sleep_q) begin
      b_valid_q  <= 1'b0;
      b_addr_q   <= '0;
      b_mask_n_q <= '1;
    end else if (go) begin
      b_valid_q  <= a_valid_q && a_write_q;
      b_addr_q   <= a_addr_q;
      b_mask_n_q <= a_mask_n_q;
    end
  end

  // Pack pins into lanes, parity on top of each byte
  always_comb begin
    wr_lanes = '0;
    for (int i = 0; i < NB; i++) begin
      wr_lanes[i*LANE_W +: LANE_W] =
        {parity_in[i], data_in[i*BYTE_W +: BYTE_W]};
    end
  end

  assign mif.wr_en   = go && b_valid_q;
  assign mif.wr_addr = b_addr_q;
  assign mif.wr_lane = ~b_mask_n_q;
  assign mif.wr_data = wr_lanes;
  assign mif.rd_addr = a_addr_q;

  pbsp_mem #(.AW(AW), .NB(NB)) u_mem (
    .sys_clk (sys_clk),
    .port    (mif)
  );

  // ****************************************
  // Read output stage
  // ****************************************
  // Array still holds old data at the commit edge, so forward lanes
  assign hit = mif.wr_en && (b_addr_q == a_addr_q);

  always_comb begin
    rd_merged = mif.rd_data;
    for (int i = 0; i < NB; i++) begin
      if (hit && !b_mask_n_q[i]) begin
        rd_merged[i*LANE_W +: LANE_W] = wr_lanes[i*LANE_W +: LANE_W];
      end
    end
  end

  // Drive flag: reads only; writes and deselects clear it
  always_ff @(posedge sys_clk) begin
    if (!rst_n || sleep_q) begin
      drive_q <= 1'b0;
    end else if (go) begin
      drive_q <= a_valid_q && !a_write_q;
    end
  end

  // Output register loads only on a read beat
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dout_q <= '0;
    end else if (go && a_valid_q && !a_write_q) begin
      dout_q <= rd_merged;
    end
  end

  // Unpack lanes to pins
  always_comb begin
    data_out   = '0;
    parity_out = '0;
    for (int i = 0; i < NB; i++) begin
      data_out[i*BYTE_W +: BYTE_W] = dout_q[i*LANE_W +: BYTE_W];
      parity_out[i] = dout_q[i*LANE_W + BYTE_W];
    end
  end

  // Enable is asynchronous on purpose: it gates the pad directly
  assign data_oe      = drive_q && !output_enable_n && !sleep_q;
  assign parity_oe    = data_oe;
  assign sleep_active = sleep_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_read_cmd;  go && cmd == CMD_READ;  endsequence
  sequence s_write_cmd; go && cmd == CMD_WRITE; endsequence
  sequence s_idle_cmd;  go && cmd == CMD_IDLE;  endsequence

  chk_stall_hold: assert property (
    clock_qualify_n && !sleep_q |=>
      $stable({a_valid_q, a_addr_q, b_valid_q, drive_q, dout_q}))
    else $error("state changed on a stalled edge");
  chk_addr_load: assert property (
    s_read_cmd or s_write_cmd |=> a_addr_q == $past(address))
    else $error("address not captured");
  chk_read_drive: assert property (
    s_read_cmd ##1 go |=> drive_q)
    else $error("read data not presented after next edge");
  chk_deselect_off: assert property (
    s_idle_cmd ##1 go |=> !drive_q && !data_oe)
    else $error("outputs live after deselect");
  chk_write_float: assert property (
    s_write_cmd ##1 go |=> !data_oe && !parity_oe)
    else $error("lines driven in write data cycle");
  chk_write_commit: assert property (
    s_write_cmd ##1 go ##1 go |-> mif.wr_en && mif.wr_addr == $past(a_addr_q))
    else $error("write not committed at second edge");
  chk_burst_type: assert property (
    go && cmd == CMD_STEP && burst_live_q |=>
      a_valid_q && a_write_q == $past(burst_write_q))
    else $error("burst type not kept");
  // Flush is checked one edge on, so a dead reset branch would show
  chk_sleep_float: assert property (
    sleep_q |=> !drive_q && !a_valid_q && !b_valid_q)
    else $error("pending work kept while asleep");

endmodule : pbsp_top

// >>> test/pbsp_ctl_model.sv
// Controller data side: puts write data on the input lanes.
// Assumes it sees the same command pins that the bench drives.
`timescale 1ns/100ps

module pbsp_ctl_model (
  input  wire logic        sys_clk,
  input  wire logic        clock_qualify_n,
  input  wire logic        sel_all,
  input  wire logic        burst_step_or_load,
  input  wire logic        write_n,
  output logic      [31:0] data_in,
  output logic      [3:0]  parity_in
);
  // ****************************************
  // Write data queue and beat tracking
  // ****************************************
  logic [35:0] wq [$];   // Words for coming write beats
  logic        wr_type_q; // Burst in flight is a write
  logic        beat_q;    // Write beat taken at the last edge

  // Bench hands over one word per write beat
  function automatic void push(input logic [35:0] v);
    wq.push_back(v);
  endfunction : push

  initial begin
    data_in   <= 32'h0;
    parity_in <= 4'h0;
    wr_type_q <= 1'b0;
    beat_q    <= 1'b0;
  end

  // Frozen edges leave our data alone
  always @(posedge sys_clk) begin
    if (!clock_qualify_n) begin
      // Hold data through the commit edge
      if (beat_q && wq.size() > 0) begin
        {parity_in, data_in} <= wq.pop_front();
      end else begin
        // Released lanes: inverse, not a stale copy
        {parity_in, data_in} <= ~{parity_in, data_in};
      end
      // Type kept across steps
      if (!burst_step_or_load) begin
        wr_type_q <= sel_all & ~write_n;
      end
      beat_q <= burst_step_or_load ? wr_type_q : (sel_all & ~write_n);
    end
  end
endmodule : pbsp_ctl_model

// >>> test/pbsp_top_bench.sv
// Self-checking bench for the burst SRAM access port.
// Assumes the controller model drives write data on the input lanes.
`timescale 1ns/100ps

module pbsp_top_bench;
  import pbsp_pkg::*;
  // ****************************************
  // Setup
  // ****************************************
  localparam int AW = 6;           // Small array keeps the model cheap
  localparam int CYC_LIMIT = 1000; // Tests need about a hundred cycles
  localparam logic [2:0] K_IDLE = 3'h0, K_RD = 3'h1, K_WR = 3'h2;
  localparam logic [2:0] K_STEP = 3'h3, K_STALL = 3'h4;
  logic          sys_clk, rst_n, clock_qualify_n, burst_step_or_load;
  logic          chip_select_one_n, chip_select_two, chip_select_three_n;
  logic          write_n, burst_order, output_enable_n, sleep_request;
  logic          data_oe, parity_oe, sleep_active, sel_all;
  logic [3:0]    byte_lane_write_n, parity_in, parity_out;
  logic [AW-1:0] address;
  logic [31:0]   data_in, data_out;
  logic [35:0]   exp_mem [64];     // Expected array contents
  int            n_mismatch, checks_done, cyc;

  assign sel_all = ~chip_select_one_n & chip_select_two & ~chip_select_three_n;

  pbsp_top #(.AW(AW), .NB(4)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clock_qualify_n(clock_qualify_n),
    .chip_select_one_n(chip_select_one_n),
    .chip_select_two(chip_select_two),
    .chip_select_three_n(chip_select_three_n),
    .burst_step_or_load(burst_step_or_load), .write_n(write_n),
    .byte_lane_write_n(byte_lane_write_n), .address(address),
    .burst_order(burst_order), .output_enable_n(output_enable_n),
    .sleep_request(sleep_request), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .parity_in(parity_in),
    .parity_out(parity_out), .parity_oe(parity_oe),
    .sleep_active(sleep_active));

  pbsp_ctl_model ctl (
    .sys_clk(sys_clk), .clock_qualify_n(clock_qualify_n),
    .sel_all(sel_all), .burst_step_or_load(burst_step_or_load),
    .write_n(write_n), .data_in(data_in), .parity_in(parity_in));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic close_out();
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk_w(input string nm, input logic [35:0] e,
                       input logic [35:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_w

  task automatic chk_b(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_b

  // Distinct value in every lane and parity bit
  function automatic logic [35:0] word(input logic [7:0] n);
    return {n[3:0], n + 8'h3, n + 8'h2, n + 8'h1, n};
  endfunction : word

  // Beat address: only the two low bits move
  function automatic logic [AW-1:0] bad(input logic [AW-1:0] a,
                                        input logic o, input int n);
    return {a[AW-1:2], o ? a[1:0] ^ n[1:0] : a[1:0] + n[1:0]};
  endfunction : bad

  // Update expected lanes and queue the word for the controller
  function automatic void put(input logic [AW-1:0] a, input logic [3:0] m,
                              input logic [35:0] d);
    for (int i = 0; i < 4; i++) begin
      if (!m[i]) begin
        exp_mem[a][8*i +: 8] = d[8*i +: 8];
        exp_mem[a][32+i]     = d[32+i];
      end
    end
    ctl.push(d);
  endfunction : put

  // One command edge; steps deselect and flip write to prove they are moot
  task automatic op(input logic [2:0] k, input logic [AW-1:0] a,
                    input logic [3:0] m);
    @(posedge sys_clk);
    clock_qualify_n     <= (k == K_STALL);
    chip_select_one_n   <= (k == K_IDLE);
    chip_select_two     <= (k != K_STEP);
    chip_select_three_n <= (k == K_STEP);
    burst_step_or_load  <= (k == K_STEP);
    write_n             <= (k == K_STEP) ? ~write_n : (k != K_WR);
    byte_lane_write_n   <= m;
    address             <= (k == K_STEP) ? ~a : a;
    @(negedge sys_clk);
  endtask : op

  task automatic rd_chk(input logic [AW-1:0] a);
    chk_w("read_word", exp_mem[a], {parity_out, data_out});
    chk_b("data_oe", 1'b1, data_oe);
    chk_b("parity_oe", 1'b1, parity_oe);
  endtask : rd_chk

  task automatic rd(input logic [AW-1:0] a);
    op(K_RD, a, 4'hf);
    op(K_IDLE, 6'h00, 4'hf);
    op(K_IDLE, 6'h00, 4'hf);
  endtask : rd

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_single();
    put(6'h05, 4'h0, word(8'h11));
    op(K_WR, 6'h05, 4'h0);
    op(K_RD, 6'h05, 4'hf);    // Read right behind the write
    op(K_IDLE, 6'h00, 4'hf);
    chk_b("oe_after_write", 1'b0, data_oe);
    op(K_IDLE, 6'h00, 4'hf);
    rd_chk(6'h05);
    op(K_IDLE, 6'h00, 4'hf);
    chk_b("oe_deselect", 1'b0, data_oe);
  endtask : t_single

  // Partial lanes, then a write with no lanes at all
  task automatic t_mask();
    logic [3:0] masks [2];
    masks = '{4'h5, 4'hf};
    for (int j = 0; j < 2; j++) begin
      put(6'h05, masks[j], word(8'h40 + 8'(j)));
      op(K_WR, 6'h05, masks[j]);
      op(K_IDLE, 6'h00, 4'hf);
      rd(6'h05);
      rd_chk(6'h05);
    end
  endtask : t_mask

  task automatic t_burst(input logic ord, input logic wr,
                         input logic [AW-1:0] a, input logic pass);
    logic [3:0] m;
    @(posedge sys_clk) burst_order <= ord;
    repeat (3) op(K_IDLE, 6'h00, 4'hf);    // Strap synchroniser settles
    // Four steps wrap back to the start beat
    for (int n = 0; n < 7; n++) begin
      m = (pass && n == 2) ? 4'hc : 4'h0;  // Per-beat lanes
      if (wr && n < 5) put(bad(a, ord, n), m, word(8'h80 + 8'(4*pass + n)));
      op((n == 0) ? (wr ? K_WR : K_RD) : (n < 5 ? K_STEP : K_IDLE), a, m);
      if (!wr && n >= 2) rd_chk(bad(a, ord, n - 2));
    end
  endtask : t_burst

  task automatic t_stall();
    op(K_RD, 6'h05, 4'hf);
    repeat (3) op(K_STALL, 6'h0b, 4'h0);  // Frozen edges carry a read
    op(K_IDLE, 6'h00, 4'hf);
    chk_b("oe_stalled", 1'b0, data_oe);
    op(K_IDLE, 6'h00, 4'hf);
    rd_chk(6'h05);
  endtask : t_stall

  task automatic t_oe();
    @(posedge sys_clk) output_enable_n <= 1'b1;
    rd(6'h08);
    chk_b("oe_pin_high", 1'b0, data_oe);
    chk_w("read_word", exp_mem[8], {parity_out, data_out});
    @(posedge sys_clk) output_enable_n <= 1'b0;
  endtask : t_oe

  // Entered while deselected, left with selects idle
  task automatic t_sleep();
    @(posedge sys_clk) sleep_request <= 1'b1;
    repeat (SLEEP_CYCLES) @(negedge sys_clk);
    chk_b("sleep_one_edge", 1'b0, sleep_active);
    @(negedge sys_clk);
    chk_b("sleep_two_edges", 1'b1, sleep_active);
    @(posedge sys_clk) sleep_request <= 1'b0;
    repeat (SLEEP_CYCLES) @(negedge sys_clk);
    chk_b("wake_one_edge", 1'b1, sleep_active);
    @(negedge sys_clk);
    chk_b("wake_two_edges", 1'b0, sleep_active);
    repeat (2) op(K_IDLE, 6'h00, 4'hf);
    rd(6'h0a);
    rd_chk(6'h0a);
  endtask : t_sleep

  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == CYC_LIMIT) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    {rst_n, sleep_request, burst_order, output_enable_n} <= 4'h0;
    {clock_qualify_n, burst_step_or_load, chip_select_two} <= 3'h0;
    {chip_select_one_n, chip_select_three_n, write_n} <= 3'h7;
    byte_lane_write_n <= 4'hf;
    address <= 6'h00;
    n_mismatch = 0;
    checks_done = 0;
    cyc <= 0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk_b("oe_reset", 1'b0, data_oe);
    chk_b("sleep_reset", 1'b0, sleep_active);
    t_single();
    t_mask();
    t_burst(1'b0, 1'b1, 6'h0b, 1'b0);
    t_burst(1'b0, 1'b1, 6'h0a, 1'b1);
    t_burst(1'b1, 1'b0, 6'h09, 1'b0);
    t_burst(1'b0, 1'b0, 6'h0b, 1'b0);
    t_stall();
    t_oe();
    t_sleep();
    close_out();
  end
endmodule : pbsp_top_bench
